// ---- bench/mpc_config_reg_properties.sv ----
`timescale 1ns/1ps
module mpc_cfg_props
    import mpc_pkg::*;
(
    input wire logic                       core_clk,
    input wire logic                       reset_n,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [mpc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire logic                       wb_err_o,
    input wire logic                       clockSpreading,
    input wire logic                       missingMotorCheck,
    input wire logic [1:0]                 fluxWeakSel,
    input wire logic [1:0]                 refWindowSel,
    input wire logic                       loopsSuspended,
    input wire logic                       powerCapActive,
    input wire logic                       speedLimitActive,
    input wire logic                       reverseDrive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // full-word write of the configuration register being acknowledged
    sequence cfg_wr;
        wb_ack_o && wb_we_i && wb_adr_i == 8'haa && wb_sel_i == 4'hf;
    endsequence
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_spread_follows: assert property (cfg_wr |=> clockSpreading == !$past(wb_dat_i[30]))
        else $error("clock spreading wrong after write");
    a_miss_check_off: assert property (cfg_wr ##0 wb_dat_i[28] |=> !missingMotorCheck)
        else $error("missing motor check still on");
    a_flux_follows: assert property (cfg_wr |=> fluxWeakSel == $past(wb_dat_i[25:24]))
        else $error("flux setpoint wrong");
    a_window_follows: assert property (cfg_wr |=> refWindowSel == $past(wb_dat_i[23:22]))
        else $error("window select wrong");
    a_window_off: assert property ($past(refWindowSel) == 2'h0 && refWindowSel == 2'h0 |-> !loopsSuspended)
        else $error("loops suspended with window off");
    a_power_cap: assert property (cfg_wr |=> powerCapActive == ($past(wb_dat_i[21]) && $past(wb_dat_i[8:7]) != 2'h1))
        else $error("power cap wrong");
    a_speed_limit: assert property (cfg_wr |=> speedLimitActive == ($past(wb_dat_i[17]) && $past(wb_dat_i[8:7]) != 2'h0))
        else $error("speed limit wrong");
    a_reserved_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'haa |-> (wb_dat_o & 32'h2000000f) == 32'h0)
        else $error("reserved bits read nonzero");
    a_reverse_pulse: assert property (reverseDrive |=> !reverseDrive)
        else $error("reverse drive pulse too long");
endmodule
bind mpc_config_reg mpc_cfg_props u_props (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .clockSpreading,
    .missingMotorCheck, .fluxWeakSel, .refWindowSel, .loopsSuspended, .powerCapActive,
    .speedLimitActive, .reverseDrive);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import mpc_pkg::*;
    logic        core_clk = 0, reset_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, lastErr;
    logic [7:0]  wbAdr    = 0;
    logic [3:0]  wbSel    = 0;
    logic [31:0] wbDatI   = 0, wbDatO, q, d;
    logic        dirPin = 0, lockEn = 1, bemfRaw = 0, eTick = 0, inWindow = 1;
    logic        stopDone = 0, isdDone = 0, wbAck, wbErr, spread, missChk, bemfFlt;
    logic        noMot = 0, missFlt;
    logic        loopsSus, pwrCap, spdLim, dirCcw, stopReq, initial_speed_detection, revDrv, irq, irqA;
    logic [1:0]  flux, win;
    int          fails = 0, nChecks = 0, cycles = 0, n;
    mpc_config_reg #(.DG1_CYCLES(10), .DG2_CYCLES(20), .DG3_CYCLES(40)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr), .dirPin(dirPin),
        .secondLockDetectEnable(lockEn), .badBackemfRaw(bemfRaw), .elecCycleTick(eTick),
        .noMotorRaw(noMot), .inWindow(inWindow), .stopDone(stopDone),
        .initialSpeedDetectionDone(isdDone), .clockSpreading(spread),
        .missingMotorCheck(missChk), .missingMotorFault(missFlt), .badBackemfFault(bemfFlt),
        .fluxWeakSel(flux), .refWindowSel(win), .loopsSuspended(loopsSus),
        .powerCapActive(pwrCap), .speedLimitActive(spdLim), .dirCcw(dirCcw),
        .motorStopReq(stopReq), .initialSpeedDetection(initial_speed_detection), .reverseDrive(revDrv), .irq(irq));
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dv);
        @(posedge core_clk);
        wbCyc <= 1;
        wbStb <= 1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= 4'hf;
        wbDatI <= dv;
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'b1 && wbErr !== 1'b1);
        q = wbDatO;
        lastErr = wbErr;
        wbCyc <= 0;
        wbStb <= 0;
        @(posedge core_clk);
    endtask
    task automatic waitv(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_basic();
        wb(0, 8'haa, 0);
        chk("cfg reset", 0, q);
        chk("spread reset", 1, spread);
        wb(1, 8'h10, 32'hffffffff);
        chk("unmapped err", 1, lastErr);
        wb(1, 8'haa, 32'hffffffff);
        wb(0, 8'haa, 0);
        chk("reserved read", 32'hdffffff0, q);
        chk("spread off", 0, spread);
        chk("miss off", 0, missChk);
        wb(1, 8'haa, 0);
        repeat (2) @(posedge core_clk);
        chk("miss on", 1, missChk);
        noMot <= 1;
        repeat (4) @(posedge core_clk);
        chk("no motor fault", 1, missFlt);
        lockEn <= 0;
        repeat (5) @(posedge core_clk);
        chk("miss no lock", 0, missChk);
        chk("no motor no lock", 0, missFlt);
        noMot <= 0;
    endtask
    task automatic t_fields();
        for (int k = 0; k < 4; k++) begin
            d = (k << 24) | (k << 22) | (k << 19) | (k << 7) | 32'h00260000;
            wb(1, 8'haa, d);
            repeat (4) @(posedge core_clk);
            chk("flux", k, flux);
            chk("window", k, win);
            chk("loops", k != 0, loopsSus);
            chk("power cap", k != 1, pwrCap);
            chk("speed limit", k != 0, spdLim);
            chk("ccw", k == 2, dirCcw);
            wb(0, 8'haa, 0);
            chk("readback", d, q);
        end
    endtask
    task automatic t_dir_stop();
        wb(1, 8'haa, 0);
        wb(1, 8'hb4, 32'h1);
        dirPin <= 1;
        waitv(stopReq, 1, 20);
        chk("stop req", 1, stopReq);
        chk("isd early", 0, initial_speed_detection);
        stopDone <= 1;
        waitv(initial_speed_detection, 1, 20);
        stopDone <= 0;
        chk("isd run", 1, initial_speed_detection);
        chk("stop released", 0, stopReq);
        isdDone <= 1;
        waitv(initial_speed_detection, 0, 20);
        isdDone <= 0;
        chk("isd end", 0, initial_speed_detection);
        wb(0, 8'hb0, 0);
        chk("dir status", 1, q[0]);
        irqA = irq;
        wb(1, 8'hb4, 0);
        chk("irq mask", 1, irqA ^ irq);
        wb(1, 8'hb0, 32'h1);
        wb(0, 8'hb0, 0);
        chk("status clear", 0, q[0]);
        chk("irq clear", 0, irq);
    endtask
    task automatic t_reverse();
        wb(1, 8'haa, 32'h00040000);
        irqA = dirCcw;
        dirPin <= 0;
        waitv(revDrv, 1, 20);
        chk("reverse pulse", 1, revDrv);
        chk("no stop", 0, stopReq);
        repeat (2) @(posedge core_clk);
        chk("dir flipped", !irqA, dirCcw);
    endtask
    task automatic t_bemf();
        for (int c = 1; c < 4; c++) begin
            wb(1, 8'haa, c << 26);
            bemfRaw <= 1;
            waitv(bemfFlt, 1, 100);
            chk("deglitch time", 1, n >= (10 << (c - 1)) && n <= (10 << (c - 1)) + 8);
            bemfRaw <= 0;
            waitv(bemfFlt, 0, 20);
        end
        wb(1, 8'haa, 0);
        bemfRaw <= 1;
        repeat (30) @(posedge core_clk);
        chk("no ticks", 0, bemfFlt);
        repeat (2) begin
            eTick <= 1;
            repeat (2) @(posedge core_clk);
            eTick <= 0;
            repeat (2) @(posedge core_clk);
        end
        waitv(bemfFlt, 1, 10);
        chk("two ticks", 1, bemfFlt);
        bemfRaw <= 0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        t_basic();
        t_fields();
        t_dir_stop();
        t_reverse();
        t_bemf();
        end_sim();
    end
endmodule

// ---- verilog/mpc_config_reg.sv ----
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: register at 0xaa, resets to zero
// R2: bit30 one turns clock spreading off
// R3: bit28 zero enables missing-motor check with lock2
// R4: bits27-26 pick bad back-EMF deglitch time
// R5: bits25-24 pick flux-weakening setpoint
// R6: bits23-22 reference window suspends control loops
// R7: bit21 caps bus power except power mode
// R8: bits20-19 choose direction source
// R9: bit18 zero: stop, then initial speed detection
// R10: bit18 one: reverse drive without stopping
// R11: bit17 limits speed except speed mode
// R12: reserved bits read zero, parity stored
// R13: fields kept until rewritten or reset
module mpc_config_reg
    import mpc_pkg::*;
#(
    parameter longint DG1_CYCLES = mpc_pkg::DG1_CYC,
    parameter longint DG2_CYCLES = mpc_pkg::DG2_CYC,
    parameter longint DG3_CYCLES = mpc_pkg::DG3_CYC
) (
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [mpc_pkg::ADDR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    output logic                             wb_err_o,
    input  wire logic                        dirPin,
    input  wire logic                        secondLockDetectEnable,
    input  wire logic                        badBackemfRaw,
    input  wire logic                        elecCycleTick,
    input  wire logic                        noMotorRaw,
    input  wire logic                        inWindow,
    input  wire logic                        stopDone,
    input  wire logic                        initialSpeedDetectionDone,
    output logic                             clockSpreading,
    output logic                             missingMotorCheck,
    output logic                             missingMotorFault,
    output logic                             badBackemfFault,
    output logic      [1:0]                  fluxWeakSel,
    output logic      [1:0]                  refWindowSel,
    output logic                             loopsSuspended,
    output logic                             powerCapActive,
    output logic                             speedLimitActive,
    output logic                             dirCcw,
    output logic                             motorStopReq,
    output logic                             initialSpeedDetection,
    output logic                             reverseDrive,
    output logic                             irq
);
    import mpc_pkg::*;

    if (DG1_CYCLES < 1 || DG2_CYCLES < DG1_CYCLES || DG3_CYCLES < DG2_CYCLES
        || DG3_CYCLES > 64'h00000000ffffffff) begin
        $error("mpc_config_reg: bad deglitch counts");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] dirSync_r;
    logic [1:0] lockSync_r;
    logic [1:0] bemfSync_r;
    logic [1:0] tickSync_r;
    logic [1:0] noMotSync_r;
    logic [1:0] winSync_r;
    logic       dirPrev_r;
    logic       tickPrev_r;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            dirSync_r   <= 2'h0;
            lockSync_r  <= 2'h0;
            bemfSync_r  <= 2'h0;
            tickSync_r  <= 2'h0;
            noMotSync_r <= 2'h0;
            winSync_r   <= 2'h0;
            dirPrev_r   <= 1'b0;
            tickPrev_r  <= 1'b0;
        end else begin
            dirSync_r   <= {dirSync_r[0], dirPin};
            lockSync_r  <= {lockSync_r[0], secondLockDetectEnable};
            bemfSync_r  <= {bemfSync_r[0], badBackemfRaw};
            tickSync_r  <= {tickSync_r[0], elecCycleTick};
            noMotSync_r <= {noMotSync_r[0], noMotorRaw};
            winSync_r   <= {winSync_r[0], inWindow};
            dirPrev_r   <= dirSync_r[1];
            tickPrev_r  <= tickSync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave
    logic [31:0]        cfg_r;
    logic [IRQ_W-1:0]   irqStat_r;
    logic [IRQ_W-1:0]   irqMask_r;
    logic [31:0]        wmask;
    logic               req;
    logic               hitCfg;
    logic               hitStat;
    logic               hitMask;
    logic               hitCtrl;
    logic [31:0]        rdData;

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hitCfg  = wb_adr_i == PERI_CFG_OFS;
    assign hitStat = wb_adr_i == IRQ_STAT_OFS;
    assign hitMask = wb_adr_i == IRQ_MASK_OFS;
    assign hitCtrl = wb_adr_i == CTRL_STAT_OFS;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        rdData = 32'h00000000;
        if (hitCfg) begin
            rdData = cfg_r;                                        // [R12]
        end else if (hitStat) begin
            rdData[IRQ_W-1:0] = irqStat_r;
        end else if (hitMask) begin
            rdData[IRQ_W-1:0] = irqMask_r;
        end else if (hitCtrl) begin
            rdData[4:0] = {reverseDrive, initialSpeedDetection, motorStopReq, dirCcw,
                           loopsSuspended};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req && (hitCfg || hitStat || hitMask || hitCtrl);
            wb_err_o <= req && !(hitCfg || hitStat || hitMask || hitCtrl);
            wb_dat_o <= (req && !wb_we_i) ? rdData : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cfg_r <= PERI_CFG_RST;                                 // [R1]
        end else if (req && wb_we_i && hitCfg) begin
            cfg_r <= (cfg_r & ~(wmask & PERI_CFG_WMASK))
                   | (wb_dat_i & wmask & PERI_CFG_WMASK);          // [R12] [R13]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irqMask_r <= '0;
        end else if (req && wb_we_i && hitMask && wb_sel_i[0]) begin
            irqMask_r <= wb_dat_i[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field decode
    logic [1:0] dgSel;
    logic [1:0] dirSel;
    logic [1:0] refMode;
    logic       dirRaw;
    assign dgSel   = cfg_r[DEGLITCH_LSB+:2];
    assign dirSel  = cfg_r[DIR_SEL_LSB+:2];
    assign refMode = cfg_r[REF_MODE_LSB+:2];
    assign dirRaw  = (dirSel == DIR_FORCE_CW)  ? 1'b0 :
                     (dirSel == DIR_FORCE_CCW) ? 1'b1 : dirSync_r[1];   // [R8]

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clockSpreading    <= 1'b1;
            missingMotorCheck <= 1'b0;
            fluxWeakSel       <= 2'h0;
            refWindowSel      <= 2'h0;
            loopsSuspended    <= 1'b0;
            powerCapActive    <= 1'b0;
            speedLimitActive  <= 1'b0;
        end else begin
            clockSpreading    <= !cfg_r[SPREAD_OFF_BIT];                       // [R2]
            missingMotorCheck <= !cfg_r[MISS_OFF_BIT] && lockSync_r[1];         // [R3]
            fluxWeakSel       <= cfg_r[FLUX_LSB+:2];                            // [R5]
            refWindowSel      <= cfg_r[WINDOW_LSB+:2];
            loopsSuspended    <= (cfg_r[WINDOW_LSB+:2] != 2'h0) && winSync_r[1]; // [R6]
            powerCapActive    <= cfg_r[PWR_LIM_BIT] && refMode != REF_POWER;    // [R7]
            speedLimitActive  <= cfg_r[SPD_LIM_BIT] && refMode != REF_SPEED;    // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bad back-emf deglitch
    logic [31:0] dgCnt_r;
    logic [1:0]  ecycCnt_r;
    logic [31:0] dgLimit;
    logic        tickEdge;
    assign tickEdge = tickSync_r[1] && !tickPrev_r;

    always_comb begin
        unique case (dgSel)
            2'h1:    dgLimit = DG1_CYCLES[31:0];
            2'h2:    dgLimit = DG2_CYCLES[31:0];
            2'h3:    dgLimit = DG3_CYCLES[31:0];
            2'h0:    dgLimit = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            dgCnt_r         <= 32'h00000000;
            ecycCnt_r       <= 2'h0;
            badBackemfFault <= 1'b0;
        end else if (!bemfSync_r[1]) begin
            dgCnt_r         <= 32'h00000000;
            ecycCnt_r       <= 2'h0;
            badBackemfFault <= 1'b0;
        end else if (dgSel == 2'h0) begin                                 // [R4]
            if (tickEdge && ecycCnt_r < DG0_ECYC[1:0]) begin
                ecycCnt_r <= ecycCnt_r + 2'h1;
            end
            badBackemfFault <= ecycCnt_r >= DG0_ECYC[1:0];
        end else begin
            if (dgCnt_r < dgLimit) begin
                dgCnt_r <= dgCnt_r + 32'h1;
            end
            badBackemfFault <= dgCnt_r >= dgLimit;                       // [R4]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            missingMotorFault <= 1'b0;
        end else begin
            missingMotorFault <= missingMotorCheck && noMotSync_r[1];   // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direction change sequencer
    mpc_dir_st_t st_r;
    logic        dirChg;
    assign dirChg = dirRaw != dirCcw;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r                  <= ST_RUN;
            dirCcw                <= 1'b0;
            motorStopReq          <= 1'b0;
            initialSpeedDetection <= 1'b0;
            reverseDrive          <= 1'b0;
        end else begin
            unique case (st_r)
                ST_RUN: begin
                    if (dirChg && cfg_r[DIR_MODE_BIT]) begin
                        dirCcw       <= dirRaw;
                        reverseDrive <= 1'b1;
                        st_r         <= ST_REV;                          // [R10]
                    end else if (dirChg) begin
                        motorStopReq <= 1'b1;
                        st_r         <= ST_STOP;                         // [R9]
                    end
                end
                ST_REV: begin
                    reverseDrive <= 1'b0;
                    st_r         <= ST_RUN;
                end
                ST_STOP: begin
                    if (stopDone) begin
                        motorStopReq          <= 1'b0;
                        initialSpeedDetection <= 1'b1;
                        dirCcw                <= dirRaw;
                        st_r                  <= ST_ISD;                 // [R9]
                    end
                end
                ST_ISD: begin
                    if (initialSpeedDetectionDone) begin
                        initialSpeedDetection <= 1'b0;
                        st_r                  <= ST_RUN;
                    end
                end
                default: st_r <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts
    logic [IRQ_W-1:0] evt;
    logic             faultPrevB_r;
    logic             faultPrevM_r;
    assign evt[IRQ_DIR_CHG] = st_r == ST_RUN && dirChg;
    assign evt[IRQ_BEMF]    = badBackemfFault && !faultPrevB_r;
    assign evt[IRQ_NOMOTOR] = missingMotorFault && !faultPrevM_r;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irqStat_r    <= '0;
            faultPrevB_r <= 1'b0;
            faultPrevM_r <= 1'b0;
            irq          <= 1'b0;
        end else begin
            faultPrevB_r <= badBackemfFault;
            faultPrevM_r <= missingMotorFault;
            if (req && wb_we_i && hitStat && wb_sel_i[0]) begin
                irqStat_r <= (irqStat_r & ~wb_dat_i[IRQ_W-1:0]) | evt;
            end else begin
                irqStat_r <= irqStat_r | evt;
            end
            irq <= |(irqStat_r & irqMask_r);
        end
    end
endmodule

// ---- verilog/mpc_pkg.sv ----
package mpc_pkg;
    localparam int        ADDR_W            = 8;
    // register byte addresses
    localparam logic [7:0] PERI_CFG_OFS     = 8'haa;
    localparam logic [7:0] IRQ_STAT_OFS     = 8'hb0;
    localparam logic [7:0] IRQ_MASK_OFS     = 8'hb4;
    localparam logic [7:0] CTRL_STAT_OFS    = 8'hb8;
    localparam logic [31:0] PERI_CFG_RST    = 32'h00000000;
    localparam logic [31:0] PERI_CFG_WMASK  = 32'hdffffff0;
    // field positions
    localparam int PARITY_BIT     = 31;
    localparam int SPREAD_OFF_BIT = 30;
    localparam int MISS_OFF_BIT   = 28;
    localparam int DEGLITCH_LSB   = 26;
    localparam int FLUX_LSB       = 24;
    localparam int WINDOW_LSB     = 22;
    localparam int PWR_LIM_BIT    = 21;
    localparam int DIR_SEL_LSB    = 19;
    localparam int DIR_MODE_BIT   = 18;
    localparam int SPD_LIM_BIT    = 17;
    localparam int REF_MODE_LSB   = 7;
    // reference modes
    localparam logic [1:0] REF_SPEED = 2'h0;
    localparam logic [1:0] REF_POWER = 2'h1;
    // direction sources
    localparam logic [1:0] DIR_FORCE_CW  = 2'h1;
    localparam logic [1:0] DIR_FORCE_CCW = 2'h2;
    // deglitch times in ms and cycle counts at 200 MHz
    localparam longint CLK_HZ       = 200000000;
    localparam longint DG1_MS       = 500;
    localparam longint DG2_MS       = 1000;
    localparam longint DG3_MS       = 2000;
    localparam longint DG1_CYC      = DG1_MS * CLK_HZ / 1000;
    localparam longint DG2_CYC      = DG2_MS * CLK_HZ / 1000;
    localparam longint DG3_CYC      = DG3_MS * CLK_HZ / 1000;
    localparam int     DG0_ECYC     = 2;
    // interrupt status bits
    localparam int IRQ_DIR_CHG  = 0;
    localparam int IRQ_BEMF     = 1;
    localparam int IRQ_NOMOTOR  = 2;
    localparam int IRQ_W        = 3;
    typedef enum logic [3:0] {
        ST_RUN  = 4'b0001,
        ST_STOP = 4'b0010,
        ST_ISD  = 4'b0100,
        ST_REV  = 4'b1000
    } mpc_dir_st_t;
endpackage
